/* File: bench/camera_line_io_router_tb_top.sv */
`default_nettype none
module camera_line_io_router_tb_top import clir_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic              clk_i = 1'b0;
	logic              srst_i = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [N_IN-1:0]   in_line;
	logic [2:0]        expo = '0;
	logic [CNT_W-1:0]  t_r = 16'h0005;
	logic [CNT_W-1:0]  t_g = 16'h0009;
	logic [CNT_W-1:0]  t_b = 16'h0003;
	logic              lv = 1'b0;
	logic [3:0]        lblk = '0;
	logic              step = 1'b0;
	logic              sense = 1'b0;
	logic [N_OUT-1:0]  out_line;
	logic              cap;
	logic [15:0]       level;
	logic [DATA_W-1:0] v;
	int                errors = 0;
	int                checks = 0;
	int                cycles = 0;
	int                ones;
	int                e0;
	logic [SEL_W-1:0]  codes [8];
	logic              wants [8];
	always #12.5 clk_i = ~clk_i;
	clir_line_router i_clir_line_router (
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .clk_i(clk_i),
		.srst_i(srst_i), .in_line_i(in_line), .exposure_red_i(expo[0]),
		.exposure_green_i(expo[1]), .exposure_blue_i(expo[2]),
		.exp_time_red_i(t_r), .exp_time_green_i(t_g),
		.exp_time_blue_i(t_b), .line_valid_i(lv), .logic_block_i(lblk),
		.rotary_step_pulse_i(step), .rotary_sense_i(sense),
		.out_line_o(out_line), .capture_window_o(cap),
		.all_lines_level_word_o(level)
	);
	clir_far_side i_far (.clk_i(clk_i), .lamp_i(out_line),
		.in_line_o(in_line));
	// ----------------------------------------------------------------
	// Bus tasks and checking
	// ----------------------------------------------------------------
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic settle();
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	task automatic check(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic count_ones(input int n);
		ones = 0;
		repeat (n) begin
			@(posedge clk_i);
			#1 ones += (out_line[0] === 1'b1);
		end
	endtask
	function automatic logic [15:0] lvl(input logic [5:0] i,
			input logic [3:0] o);
		logic [15:0] w;
		w = '0;
		w[0] = o[0];
		w[3] = i[0];
		w[4] = i[1];
		w[6] = i[2];
		w[7] = o[1];
		w[8] = o[2];
		w[9] = i[3];
		w[11] = o[3];
		w[12] = i[4];
		w[13] = i[5];
		return w;
	endfunction
	task automatic wrap_up();
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		codes = '{SRC_LVALID, SRC_LOGIC0, 5'h12, 5'h13, 5'h14, SRC_STEP,
			SRC_SENSE, SRC_CAPTURE};
		wants = '{1, 1, 0, 1, 0, 1, 0, 0};
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		rdr(ADDR_LINE + 8'h03);
		check("line4 sel", v, 32'h0000_001F);
		rdr(ADDR_PM + 8'h01);
		check("pm rise", v, 32'h0000_0002);
		rdr(8'h07);
		check("unmapped", v, 32'h0000_0000);
		check("level rst", level, 16'h0000);
		for (int k = 0; k < N_IN; k++) begin
			wrr(ADDR_LINE + 8'h01, 32'(SRC_IN0 + 5'(k)));
			i_far.drive(6'(1 << k));
			settle();
			check("out2 input", out_line, 4'b0010);
			check("level port", level, lvl(6'(1 << k), 4'b0010));
			rdr(ADDR_LEVEL);
			check("level reg", v, 32'(lvl(6'(1 << k), 4'b0010)));
		end
		wrr(ADDR_LINE + 8'h01, 32'h0000_001F);
		i_far.drive('0);
		for (int n = 0; n < N_OUT; n++)
			wrr(ADDR_LINE + 8'(n), 32'h0000_011F);
		settle();
		check("flip out", out_line, 4'b1111);
		check("flip level", level, lvl('0, 4'b1111));
		for (int n = 0; n < N_OUT; n++)
			wrr(ADDR_LINE + 8'(n), 32'h0000_001F);
		for (int n = 0; n < N_SW; n++) begin
			wrr(ADDR_SW_PICK, 32'(n));
			wrr(ADDR_SW_VALUE, 32'h0000_0001);
			wrr(ADDR_LINE, 32'(SRC_SW0 + 5'(n)));
			settle();
			check("sw high", out_line, 4'b0001);
			wrr(ADDR_SW_VALUE, 32'h0000_0000);
			settle();
			check("sw low", out_line, 4'b0000);
		end
		wrr(ADDR_CAPTURE, 32'h0000_0001);
		rdr(ADDR_CAPTURE);
		check("capture on", v, 32'h0000_0001);
		check("capture pin", cap, 1'b1);
		wrr(ADDR_CAPTURE, 32'h0000_0002);
		settle();
		check("capture off", cap, 1'b0);
		lv <= 1'b1;
		lblk <= 4'b0101;
		step <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			wrr(ADDR_LINE, 32'(codes[c]));
			settle();
			check("source", out_line[0], wants[c]);
		end
		lv <= 1'b0;
		expo <= 3'b010;
		wrr(ADDR_LINE, 32'(SRC_EXPOSE));
		for (int c = 0; c < 4; c++) begin
			wrr(ADDR_EXP_CHAN, 32'(c));
			settle();
			check("exp chan", out_line[0], c[0] == 1'b0);
		end
		expo <= 3'b100;
		settle();
		check("exp blue", out_line[0], 1'b1);
		t_b <= 16'h000C;
		wrr(ADDR_EXP_CHAN, 32'h0000_0000);
		settle();
		check("exp longest", out_line[0], 1'b1);
		wrr(ADDR_LINE, 32'(SRC_PM0));
		repeat (12) @(posedge clk_i);
		#1 e0 = i_far.lamp_edges;
		count_ones(20);
		check("pm width", ones, 8);
		check("lamp pulses", i_far.lamp_edges - e0, 2);
		wrr(ADDR_PM + 8'h00, 32'h0000_0008);
		wrr(ADDR_PM + 8'h01, 32'h0000_0001);
		wrr(ADDR_PM + 8'h02, 32'h0000_0007);
		repeat (20) @(posedge clk_i);
		count_ones(16);
		check("pm new", ones, 12);
		wrr(ADDR_PM + 8'h03, 32'(SRC_PM0));
		rdr(ADDR_PM + 8'h03);
		check("own clear", v, 32'h0000_001F);
		wrr(ADDR_PM + 8'h07, 32'(SRC_PM0));
		rdr(ADDR_PM + 8'h07);
		check("other clear", v, 32'h0000_0003);
		wrr(ADDR_PM + 8'h01, 32'h0000_0005);
		wrr(ADDR_PM + 8'h03, 32'(SRC_LVALID));
		rdr(ADDR_PM + 8'h03);
		check("clear pick", v, 32'(SRC_LVALID));
		ones = 0;
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_i);
			lv <= ~lv;
			#1 if (i >= 8) ones += (out_line[0] === 1'b1);
		end
		check("pm cleared", ones, 0);
		lv <= 1'b0;
		repeat (8) @(posedge clk_i);
		count_ones(16);
		check("pm free", ones, 4);
		wrr(ADDR_PM + 8'h00, 32'h0000_0010);
		wrr(ADDR_PM + 8'h03, 32'h0000_0102);
		ones = 0;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_i);
			lv <= ~lv;
			#1 if (i >= 24) ones += (out_line[0] === 1'b1);
		end
		check("pm sync", ones, 4);
		lv <= 1'b0;
		wrap_up();
	end
endmodule
`default_nettype wire

/* File: bench/clir_far_side.sv */
`default_nettype none
module clir_far_side import clir_pkg::*; (
	input  wire logic             clk_i,
	input  wire logic [N_OUT-1:0] lamp_i,
	output var  logic [N_IN-1:0]  in_line_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// Trigger sources and lighting load
	// ----------------------------------------------------------------
	logic [N_IN-1:0] want = '0;
	logic            lamp_q = 1'b0;
	int              lamp_edges = 0;
	initial in_line_o = '0;
	// Levels change just after a clock edge
	always @(posedge clk_i) in_line_o <= want;
	// Lamp on line 1 counts its switch-on events
	always @(posedge clk_i) begin
		lamp_q <= lamp_i[0];
		if (lamp_i[0] && !lamp_q)
			lamp_edges <= lamp_edges + 1;
	end
	task automatic drive(input logic [N_IN-1:0] v);
		want = v;
	endtask
endmodule
`default_nettype wire

/* File: hdl/clir_line_router.sv */
`default_nettype none
module clir_line_router import clir_pkg::*; (
	input  wire logic [ADDR_W-1:0]  reg_addr_i,
	input  wire logic [DATA_W-1:0]  reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	output var  logic [DATA_W-1:0]  reg_rdata_o,
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	input  wire logic [N_IN-1:0]    in_line_i,
	input  wire logic               exposure_red_i,
	input  wire logic               exposure_green_i,
	input  wire logic               exposure_blue_i,
	input  wire logic [CNT_W-1:0]   exp_time_red_i,
	input  wire logic [CNT_W-1:0]   exp_time_green_i,
	input  wire logic [CNT_W-1:0]   exp_time_blue_i,
	input  wire logic               line_valid_i,
	input  wire logic [3:0]         logic_block_i,
	input  wire logic               rotary_step_pulse_i,
	input  wire logic               rotary_sense_i,
	output var  logic [N_OUT-1:0]   out_line_o,
	output var  logic               capture_window_o,
	output var  logic [LEVEL_W-1:0] all_lines_level_word_o
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic pick(input logic [DATA_W-1:0] vec,
	                              input logic [SEL_W-1:0] sel);
		pick = vec[sel];
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [SEL_W-1:0] line_drive_select [N_OUT];
	logic             line_polarity_flip [N_OUT];
	logic [1:0]       software_level_pick;
	logic [N_SW-1:0]  software_level;
	clir_chan_t       exposure_window_channel;
	logic [CNT_W-1:0] pm_period [N_PM];
	logic [CNT_W-1:0] pm_rise   [N_PM];
	logic [CNT_W-1:0] pm_fall   [N_PM];
	logic [SEL_W-1:0] pulse_maker_reset_pick [N_PM];
	logic             pulse_maker_reset_sync [N_PM];
	logic [N_PM-1:0]  pulse_maker;
	logic [DATA_W-1:0] next_rdata;
	logic [LEVEL_W-1:0] next_level_word;
	logic [N_OUT-1:0] next_out;

	clir_pulse_if pm_bus [N_PM] ();

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire       wr_capture = reg_wr_i && (reg_addr_i == ADDR_CAPTURE);
	wire       wr_sw_pick = reg_wr_i && (reg_addr_i == ADDR_SW_PICK);
	wire       wr_sw_val  = reg_wr_i && (reg_addr_i == ADDR_SW_VALUE);
	wire       wr_exp     = reg_wr_i && (reg_addr_i == ADDR_EXP_CHAN);
	wire       line_hit   = reg_addr_i[7:2] == ADDR_LINE[7:2];
	wire       pm_hit     = reg_addr_i[7:4] == ADDR_PM[7:4];
	wire [1:0] line_idx   = reg_addr_i[1:0];
	wire [1:0] pm_idx     = reg_addr_i[3:2];
	wire [1:0] pm_field   = reg_addr_i[1:0];
	wire       wr_line    = reg_wr_i && line_hit;
	wire       wr_pm      = reg_wr_i && pm_hit;
	wire       cap_begin  = wr_capture && reg_wdata_i[CAP_BEGIN_BIT];
	wire       cap_end    = wr_capture && reg_wdata_i[CAP_END_BIT];
	wire [SEL_W-1:0] new_clr = reg_wdata_i[SEL_W-1:0];
	wire       clr_self   = new_clr == (SRC_PM0 + {3'b000, pm_idx});
	wire       clr_legal  = CLR_ALLOWED[new_clr] && !clr_self;
	wire       clr_accept = (new_clr == SRC_NONE) || clr_legal;

	// ----------------------------------------------------------------
	// Exposure window channel
	// ----------------------------------------------------------------
	// longest channel wins
	wire red_longest   = (exp_time_red_i >= exp_time_green_i) &&
	                     (exp_time_red_i >= exp_time_blue_i);
	wire green_longest = exp_time_green_i >= exp_time_blue_i;
	wire exp_longest   = red_longest ? exposure_red_i :
	                     green_longest ? exposure_green_i :
	                     exposure_blue_i;
	logic exposure_window;
	always_comb begin
		case (exposure_window_channel)
			CHAN_COMMON: exposure_window = exp_longest;
			CHAN_RED:    exposure_window = exposure_red_i;
			CHAN_GREEN:  exposure_window = exposure_green_i;
			CHAN_BLUE:   exposure_window = exposure_blue_i;
			default:     exposure_window = exp_longest;
		endcase
	end

	// ----------------------------------------------------------------
	// Source vector
	// ----------------------------------------------------------------
	// source set for lines
	wire [DATA_W-1:0] src_vec = {9'h000, rotary_sense_i,
	                             rotary_step_pulse_i, logic_block_i,
	                             in_line_i, software_level, pulse_maker,
	                             line_valid_i, exposure_window,
	                             capture_window_o};

	// ----------------------------------------------------------------
	// Output lines
	// ----------------------------------------------------------------
	// flip after selection
	always_comb begin
		for (int n = 0; n < N_OUT; n++) begin
			next_out[n] = pick(src_vec, line_drive_select[n]) ^
			              line_polarity_flip[n];
		end
	end

	// ----------------------------------------------------------------
	// Level word
	// ----------------------------------------------------------------
	// fixed bit positions
	always_comb begin
		next_level_word          = '0;
		next_level_word[ST_OUT1] = out_line_o[0];
		next_level_word[ST_IN1]  = in_line_i[0];
		next_level_word[ST_OPTO] = in_line_i[1];
		next_level_word[ST_LINK] = in_line_i[2];
		next_level_word[ST_OUT2] = out_line_o[1];
		next_level_word[ST_OUT3] = out_line_o[2];
		next_level_word[ST_IN2]  = in_line_i[3];
		next_level_word[ST_OUT4] = out_line_o[3];
		next_level_word[ST_IN3]  = in_line_i[4];
		next_level_word[ST_IN4]  = in_line_i[5];
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = '0;
		if (reg_rd_i) begin
			if (reg_addr_i == ADDR_LEVEL)
				next_rdata[LEVEL_W-1:0] = all_lines_level_word_o;
			else if (reg_addr_i == ADDR_CAPTURE)
				next_rdata[0] = capture_window_o;
			else if (reg_addr_i == ADDR_SW_PICK)
				next_rdata[1:0] = software_level_pick;
			else if (reg_addr_i == ADDR_SW_VALUE)
				next_rdata[0] = software_level[software_level_pick];
			else if (reg_addr_i == ADDR_EXP_CHAN)
				next_rdata[1:0] = exposure_window_channel;
			else if (line_hit) begin
				next_rdata[SEL_W-1:0] = line_drive_select[line_idx];
				next_rdata[FLIP_BIT]  = line_polarity_flip[line_idx];
			end else if (pm_hit) begin
				case (pm_field)
					PM_PERIOD: next_rdata[CNT_W-1:0] = pm_period[pm_idx];
					PM_RISE:   next_rdata[CNT_W-1:0] = pm_rise[pm_idx];
					PM_FALL:   next_rdata[CNT_W-1:0] = pm_fall[pm_idx];
					PM_CTRL: begin
						next_rdata[SEL_W-1:0] =
							pulse_maker_reset_pick[pm_idx];
						next_rdata[SYNC_BIT]  =
							pulse_maker_reset_sync[pm_idx];
					end
					default: next_rdata = '0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reg_rdata_o            <= '0;
			out_line_o             <= '0;
			all_lines_level_word_o <= '0;
			capture_window_o       <= 1'b0;
			software_level_pick    <= '0;
			software_level         <= '0;
			exposure_window_channel <= CHAN_COMMON;
		end else begin
			reg_rdata_o            <= next_rdata;
			out_line_o             <= next_out;
			all_lines_level_word_o <= next_level_word;
			capture_window_o <= cap_begin | (capture_window_o & ~cap_end);
			if (wr_sw_pick)
				software_level_pick <= reg_wdata_i[1:0];
			if (wr_sw_val)
				software_level[software_level_pick] <= reg_wdata_i[0];
			if (wr_exp)
				exposure_window_channel <= clir_chan_t'(reg_wdata_i[1:0]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int n = 0; n < N_OUT; n++) begin
				line_drive_select[n]  <= RST_LINE_SEL;
				line_polarity_flip[n] <= 1'b0;
			end
		end else if (wr_line) begin
			line_drive_select[line_idx]  <= reg_wdata_i[SEL_W-1:0];
			line_polarity_flip[line_idx] <= reg_wdata_i[FLIP_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int n = 0; n < N_PM; n++) begin
				pm_period[n]              <= RST_PERIOD;
				pm_rise[n]                <= RST_RISE;
				pm_fall[n]                <= RST_FALL;
				pulse_maker_reset_pick[n] <= RST_CLR_SEL;
				pulse_maker_reset_sync[n] <= 1'b0;
			end
		end else if (wr_pm) begin
			case (pm_field)
				PM_PERIOD: pm_period[pm_idx] <= reg_wdata_i[CNT_W-1:0];
				PM_RISE:   pm_rise[pm_idx]   <= reg_wdata_i[CNT_W-1:0];
				PM_FALL:   pm_fall[pm_idx]   <= reg_wdata_i[CNT_W-1:0];
				PM_CTRL: begin
					if (clr_accept)
						pulse_maker_reset_pick[pm_idx] <= new_clr;
					pulse_maker_reset_sync[pm_idx] <= reg_wdata_i[SYNC_BIT];
				end
				default: pm_period[pm_idx] <= pm_period[pm_idx];
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pulse makers
	// ----------------------------------------------------------------
	for (genvar g = 0; g < N_PM; g++) begin : g_pm
		assign pm_bus[g].period = pm_period[g];
		assign pm_bus[g].rise   = pm_rise[g];
		assign pm_bus[g].fall   = pm_fall[g];
		assign pm_bus[g].sync   = pulse_maker_reset_sync[g];
		assign pm_bus[g].clear  = pick(src_vec & CLR_ALLOWED,
		                               pulse_maker_reset_pick[g]);
		assign pulse_maker[g]   = pm_bus[g].pulse;
		clir_pulse_maker u_pm (
			.clk_i  (clk_i),
			.srst_i (srst_i),
			.pm     (pm_bus[g])
		);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence cap_begin_s;
		cap_begin;
	endsequence
	sequence cap_hold_s;
		capture_window_o [*2];
	endsequence

	capture_open_a: assert property (
		cap_begin_s ##1 !cap_end |-> cap_hold_s)
		else $error("capture window did not open and hold");
	capture_close_a: assert property (
		cap_end && !cap_begin |=> !capture_window_o)
		else $error("capture window did not close");
	level_inputs_a: assert property (
		##1 all_lines_level_word_o[ST_IN1] == $past(in_line_i[0]) &&
		all_lines_level_word_o[ST_IN4] == $past(in_line_i[5]) &&
		all_lines_level_word_o[ST_LINK] == $past(in_line_i[2]))
		else $error("input level at wrong status bit");
	level_outputs_a: assert property (
		##1 all_lines_level_word_o[ST_OUT4] == $past(out_line_o[3]) &&
		all_lines_level_word_o[ST_OUT1] == $past(out_line_o[0]))
		else $error("output level not mirrored");
	flip_toggle_a: assert property (
		$stable(src_vec) && $stable(line_drive_select[0]) &&
		$changed(line_polarity_flip[0]) |=> $changed(out_line_o[0]))
		else $error("flip did not invert line 1");
	input_route_a: assert property (
		line_drive_select[1] == SRC_IN0 && !line_polarity_flip[1]
		|=> out_line_o[1] == $past(in_line_i[0]))
		else $error("input routed with inversion");
	sw_level_a: assert property (
		wr_sw_val && software_level_pick == 2'd2 && !wr_line &&
		line_drive_select[0] == SRC_SW0 + 5'd2 && !line_polarity_flip[0]
		|=> ##1 out_line_o[0] == $past(reg_wdata_i[0], 2))
		else $error("software level not on line");
	exp_common_a: assert property (
		exposure_window_channel == CHAN_COMMON &&
		exp_time_blue_i > exp_time_red_i &&
		exp_time_blue_i > exp_time_green_i
		|-> exposure_window == exposure_blue_i)
		else $error("common did not pick longest channel");
	exp_chan_a: assert property (
		exposure_window_channel == CHAN_GREEN
		|-> exposure_window == exposure_green_i)
		else $error("green channel not routed");
	self_reject_a: assert property (
		wr_pm && pm_field == PM_CTRL && clr_self
		|=> pulse_maker_reset_pick[$past(pm_idx)] ==
		    $past(pulse_maker_reset_pick[pm_idx]))
		else $error("own pulse maker taken as reset");
	unmapped_read_a: assert property (
		reg_rd_i && reg_addr_i == 8'h07 |=> reg_rdata_o == '0)
		else $error("unmapped read not zero");
	line_valid_a: assert property (
		line_drive_select[0] == SRC_LVALID && !line_polarity_flip[0]
		|=> out_line_o[0] == $past(line_valid_i))
		else $error("line valid not on line 1");
	exp_red_a: assert property (
		exposure_window_channel == CHAN_RED
		|-> exposure_window == exposure_red_i)
		else $error("red channel not routed");
	clear_route_a: assert property (
		pulse_maker_reset_pick[1] == SRC_PM0
		|-> pm_bus[1].clear == pulse_maker[0])
		else $error("maker 1 reset not taken from maker 0");
	self_pick_a: assert property (
		pulse_maker_reset_pick[0] != SRC_PM0)
		else $error("maker 0 holds itself as reset");
	capture_src_a: assert property (
		line_drive_select[0] == SRC_CAPTURE && !line_polarity_flip[0]
		|=> out_line_o[0] == $past(capture_window_o))
		else $error("capture window not on line 1");
endmodule
`default_nettype wire

/* File: hdl/clir_pkg.sv */
`default_nettype none
package clir_pkg;
	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int DATA_W  = 32;
	localparam int ADDR_W  = 8;
	localparam int SEL_W   = 5;
	localparam int CNT_W   = 16;
	localparam int LEVEL_W = 16;
	localparam int N_OUT   = 4;
	localparam int N_IN    = 6;
	localparam int N_PM    = 4;
	localparam int N_SW    = 4;

	// ----------------------------------------------------------------
	// Register word indices
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_LEVEL    = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE  = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_SW_PICK  = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_SW_VALUE = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_EXP_CHAN = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_LINE     = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_PM       = 8'h10;
	localparam logic [1:0] PM_PERIOD = 2'h0;
	localparam logic [1:0] PM_RISE   = 2'h1;
	localparam logic [1:0] PM_FALL   = 2'h2;
	localparam logic [1:0] PM_CTRL   = 2'h3;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CAP_BEGIN_BIT = 0;
	localparam int CAP_END_BIT   = 1;
	localparam int FLIP_BIT      = 8;
	localparam int SYNC_BIT      = 8;
	localparam int ST_OUT1 = 0;
	localparam int ST_IN1  = 3;
	localparam int ST_OPTO = 4;
	localparam int ST_LINK = 6;
	localparam int ST_OUT2 = 7;
	localparam int ST_OUT3 = 8;
	localparam int ST_IN2  = 9;
	localparam int ST_OUT4 = 11;
	localparam int ST_IN3  = 12;
	localparam int ST_IN4  = 13;

	// ----------------------------------------------------------------
	// Source codes, order of the source vector
	// ----------------------------------------------------------------
	localparam logic [SEL_W-1:0] SRC_CAPTURE = 5'h00;
	localparam logic [SEL_W-1:0] SRC_EXPOSE  = 5'h01;
	localparam logic [SEL_W-1:0] SRC_LVALID  = 5'h02;
	localparam logic [SEL_W-1:0] SRC_PM0     = 5'h03;
	localparam logic [SEL_W-1:0] SRC_SW0     = 5'h07;
	localparam logic [SEL_W-1:0] SRC_IN0     = 5'h0B;
	localparam logic [SEL_W-1:0] SRC_LOGIC0  = 5'h11;
	localparam logic [SEL_W-1:0] SRC_STEP    = 5'h15;
	localparam logic [SEL_W-1:0] SRC_SENSE   = 5'h16;
	localparam logic [SEL_W-1:0] SRC_NONE    = 5'h1F;
	localparam logic [DATA_W-1:0] CLR_ALLOWED = 32'h003F_FFFE;

	typedef enum logic [1:0] {
		CHAN_COMMON = 2'b00,
		CHAN_RED    = 2'b01,
		CHAN_GREEN  = 2'b10,
		CHAN_BLUE   = 2'b11
	} clir_chan_t;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [SEL_W-1:0] RST_LINE_SEL = SRC_NONE;
	localparam logic [SEL_W-1:0] RST_CLR_SEL  = SRC_NONE;
	localparam logic [CNT_W-1:0] RST_PERIOD   = 16'h000A;
	localparam logic [CNT_W-1:0] RST_RISE     = 16'h0002;
	localparam logic [CNT_W-1:0] RST_FALL     = 16'h0006;
endpackage
`default_nettype wire

/* File: hdl/clir_pulse_if.sv */
`default_nettype none
interface clir_pulse_if;
	import clir_pkg::*;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] rise;
	logic [CNT_W-1:0] fall;
	logic             sync;
	logic             clear;
	logic             pulse;
	modport maker (input period, rise, fall, sync, clear, output pulse);
	modport ctrl  (output period, rise, fall, sync, clear, input pulse);
endinterface
`default_nettype wire

/* File: hdl/clir_pulse_maker.sv */
`default_nettype none
module clir_pulse_maker import clir_pkg::*; (
	input wire logic    clk_i,
	input wire logic    srst_i,
	clir_pulse_if.maker pm
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic             clear_seen;
	logic             pend;
	wire              clear_edge = pm.clear & ~clear_seen;
	wire              wrap = (pm.period == '0) ||
	                         (count >= pm.period - 16'h0001);
	wire              want = pend | clear_edge;
	wire              async_clr = ~pm.sync & clear_edge;
	wire              sync_clr = pm.sync & want & (count >= pm.fall);

	assign next_count = (async_clr | sync_clr | wrap) ? '0 :
	                    count + 16'h0001;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			count      <= '0;
			clear_seen <= 1'b0;
			pend       <= 1'b0;
			pm.pulse   <= 1'b0;
		end else begin
			count      <= next_count;
			clear_seen <= pm.clear;
			pend       <= pm.sync & (clear_edge | (pend & ~sync_clr));
			pm.pulse   <= (next_count >= pm.rise) &&
			              (next_count < pm.fall);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	async_clear_a: assert property (
		async_clr |=> (count == '0))
		else $error("async clear did not restart count");
	pulse_window_a: assert property (
		pm.pulse && $stable(pm.rise) && $stable(pm.fall)
		|-> (count >= pm.rise) && (count < pm.fall))
		else $error("pulse outside rise/fall window");
	period_wrap_a: assert property (
		(pm.period != '0) && $stable(pm.period) && !$past(clear_edge)
		&& !$past(pend) && (count < pm.period)
		|=> count < $past(pm.period))
		else $error("count ran past period");
endmodule
`default_nettype wire
